// file: design/dbc_bus.sv

`include "dbc_cfg.svh"

// ************************************************************
// Write record buffer
// ************************************************************
module dbc_fifo #(
  parameter int W = 25,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dbc_fifo_st_t;
  dbc_fifo_st_t q;
  dbc_fifo_st_t d;
  logic push;
  logic pop;

  assign in_ready_o = q.cnt != (PW+1)'(D);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == PW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == PW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // dbc_fifo

// ************************************************************
// Bus cycle engine
// ************************************************************
module dbc_bus import dbc_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Slave control pins
  input wire logic chip_select_n_i,
  input wire logic interrupt_acknowledge_n_i,
  input wire logic rw_i,
  input wire logic upper_byte_strobe_n_i,
  input wire logic lower_byte_strobe_n_i,
  input wire logic [6:0] addr_lo_i,
  // Multiplexed address/data pins
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic ad_oe_o,
  // Buffer control and acknowledge pins
  output logic buffer_direction_o,
  output logic buffer_direction_oe_o,
  output logic buffer_enable_n_o,
  output logic buffer_enable_oe_o,
  input wire logic transfer_acknowledge_n_i,
  output logic transfer_acknowledge_n_o,
  output logic transfer_acknowledge_oe_o,
  input wire logic [2:0] bus_exception_code_i,
  // Master pins
  output logic [2:0] function_code_o,
  output logic [6:0] addr_lo_o,
  output logic master_oe_o,
  output logic upper_address_strobe_n_o,
  output logic address_strobe_n_o,
  output logic rw_o,
  output logic upper_byte_strobe_n_o,
  output logic lower_byte_strobe_n_o,
  output logic periph_ack_n_o,
  output logic block_end_n_o,
  // Channel side
  input wire logic [3:0] irq_pending_i,
  input wire logic [3:0] irq_error_i,
  input wire logic [31:0] normal_vector_reg_i,
  input wire logic [31:0] error_vector_reg_i,
  input wire logic dma_start_i,
  input wire logic [1:0] dma_chan_i,
  input wire logic [2:0] dma_fc_i,
  input wire logic [23:1] dma_addr_i,
  input wire logic [1:0] dma_lanes_i,
  input wire logic dma_to_dev_i,
  input wire logic dma_last_i,
  output logic dma_busy_o,
  output logic dma_done_o,
  output logic dma_exc_o,
  output logic [15:0] dma_data_o,
  output logic cs_error_o,
  output logic [3:0] addr_error_o,
  // Register write records
  output logic wr_valid_o,
  output logic [24:0] wr_data_o,
  input wire logic wr_ready_i
);
  typedef struct packed {
    logic [31:0] sy1;
    logic [31:0] sy2;
    logic [1:0] seen;
    dbc_state_t st;
    logic [1:0] wcnt;
    logic [7:0][15:0] regs;
    logic [15:0] ad;
    logic ad_oe;
    logic dir;
    logic dir_oe;
    logic en_n;
    logic en_oe;
    logic tack_n;
    logic tack_oe;
    logic [2:0] fc;
    logic [6:0] alo;
    logic mst_oe;
    logic uas_n;
    logic as_n;
    logic rw;
    logic ub_n;
    logic lb_n;
    logic ack_n;
    logic end_n;
    logic [1:0] ch;
    logic [1:0] lanes;
    logic to_dev;
    logic last;
    logic busy;
    logic done;
    logic exc;
    logic [15:0] rdat;
    logic cs_err;
    logic [3:0] aerr;
    logic push;
    logic [24:0] pdat;
  } dbc_st_t;

  localparam dbc_st_t RST_S = '{
    st: DBC_IDLE, en_n: 1'b1, tack_n: 1'b1, uas_n: 1'b1, as_n: 1'b1, rw: 1'b1,
    ub_n: 1'b1, lb_n: 1'b1, ack_n: 1'b1, end_n: 1'b1, seen: 2'h3,
    sy1: 32'hffff_ffff, sy2: 32'hffff_ffff, default: '0};

  dbc_st_t q;
  dbc_st_t d;
  logic fifo_rdy;
  logic cs;
  logic iak;
  logic tack;
  logic exc;
  logic [7:0] vec;

  function automatic logic is_exc(input logic [2:0] c);
    return c == `DBC_BEC_BERR || c == `DBC_BEC_RETRY || c == `DBC_BEC_RELQ;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic ub_n, input logic lb_n);
    return {ub_n ? old[15:8] : nw[15:8], lb_n ? old[7:0] : nw[7:0]};
  endfunction

  // Only the second synchroniser stage is read by the logic.
  assign cs = ~q.sy2[`DBC_SY_CS];
  assign iak = ~q.sy2[`DBC_SY_IAK];
  assign tack = ~q.sy2[`DBC_SY_TACK];
  assign exc = is_exc(q.sy2[`DBC_SY_BEC]);

  // Lowest channel number wins; the vector follows that channel's error state.
  always_comb begin
    vec = 8'h00;
    for (int c = 3; c >= 0; c--) begin
      if (irq_pending_i[c]) begin
        vec = irq_error_i[c] ? error_vector_reg_i[c*8 +: 8]
                             : normal_vector_reg_i[c*8 +: 8];
      end
    end
  end

  always_comb begin
    d = q;
    d.sy1 = {ad_i, addr_lo_i, bus_exception_code_i, transfer_acknowledge_n_i,
             lower_byte_strobe_n_i, upper_byte_strobe_n_i, rw_i,
             interrupt_acknowledge_n_i, chip_select_n_i};
    d.sy2 = q.sy1;
    d.seen = {iak, cs};
    d.done = 1'b0;
    d.cs_err = 1'b0;
    d.aerr = 4'h0;
    d.push = 1'b0;
    if (q.busy && cs && !q.seen[0]) begin
      d.cs_err = 1'b1;
    end
    if (q.busy && iak && !q.seen[1]) begin
      d.aerr[q.ch] = 1'b1;
    end
    case (q.st)
      DBC_IDLE: begin
        if (cs) begin
          d.dir_oe = 1'b1;
          d.en_n = 1'b0;
          d.en_oe = 1'b1;
          if (q.sy2[`DBC_SY_RW]) begin
            d.st = DBC_RD;
            d.ad = q.regs[q.sy2[11:9]];
            d.ad_oe = 1'b1;
            d.dir = 1'b1;
            d.tack_n = 1'b0;
            d.tack_oe = 1'b1;
          end else begin
            d.st = DBC_WRE;
            d.dir = 1'b0;
          end
        end else if (iak) begin
          // Address lines and data strobes play no part here.
          d.st = DBC_IAK;
          d.ad = {8'h00, vec};
          d.ad_oe = 1'b1;
          d.dir = 1'b1;
          d.dir_oe = 1'b1;
          d.en_n = 1'b0;
          d.en_oe = 1'b1;
          d.tack_n = 1'b0;
          d.tack_oe = 1'b1;
        end else if (dma_start_i) begin
          d.st = DBC_M0;
          d.busy = 1'b1;
          d.ch = dma_chan_i;
          d.lanes = dma_lanes_i;
          d.exc = 1'b0;
          d.fc = dma_fc_i;
          d.alo = dma_addr_i[7:1];
          d.ad = dma_addr_i[23:8];
          d.ad_oe = 1'b1;
          d.mst_oe = 1'b1;
          d.uas_n = 1'b0;
          d.rw = 1'b1;
          d.to_dev = dma_to_dev_i;
          d.last = dma_last_i;
        end
      end
      DBC_RD: begin
        if (!cs) begin
          d.st = DBC_IDLE;
          d.ad_oe = 1'b0;
          d.dir_oe = 1'b0;
          d.en_oe = 1'b0;
          d.en_n = 1'b1;
          d.tack_oe = 1'b0;
          d.tack_n = 1'b1;
        end
      end
      DBC_IAK: begin
        if (!iak) begin
          d.st = DBC_IDLE;
          d.ad_oe = 1'b0;
          d.dir = 1'b0;
          d.dir_oe = 1'b0;
          d.en_oe = 1'b0;
          d.en_n = 1'b1;
          d.tack_oe = 1'b0;
          d.tack_n = 1'b1;
        end
      end
      DBC_WRE, DBC_WRA: begin
        if (!cs) begin
          d.st = DBC_IDLE;
          d.dir_oe = 1'b0;
          d.en_oe = 1'b0;
          d.en_n = 1'b1;
          d.tack_oe = 1'b0;
          d.tack_n = 1'b1;
        end else if (q.st == DBC_WRE && fifo_rdy) begin
          // A full record buffer stalls the acknowledge, not the capture order.
          d.st = DBC_WRA;
          d.regs[q.sy2[11:9]] = merge(q.regs[q.sy2[11:9]], q.sy2[`DBC_SY_DAT],
                                      q.sy2[`DBC_SY_UB], q.sy2[`DBC_SY_LB]);
          d.push = 1'b1;
          d.pdat = {q.sy2[`DBC_SY_ADR], q.sy2[`DBC_SY_UB], q.sy2[`DBC_SY_LB],
                    q.sy2[`DBC_SY_DAT]};
          d.tack_n = 1'b0;
          d.tack_oe = 1'b1;
        end
      end
      DBC_M0: d.st = DBC_M1;
      DBC_M1: begin
        d.st = DBC_M2;
        d.uas_n = 1'b1;
        d.as_n = 1'b0;
        d.ub_n = ~q.lanes[1];
        d.lb_n = ~q.lanes[0];
        d.dir = 1'b0;
        d.dir_oe = 1'b1;
        // The device handshake waits for S2, so it never precedes the address strobe.
        d.ack_n = ~q.to_dev;
        d.end_n = ~(q.to_dev && q.last);
      end
      DBC_M2: begin
        d.st = DBC_M3;
        d.ad_oe = 1'b0;
        d.en_n = 1'b0;
        d.en_oe = 1'b1;
      end
      DBC_M3: begin
        if (tack) begin
          d.st = DBC_M4;
        end else if (exc) begin
          d.st = DBC_MX;
          d.wcnt = 2'h1;
          d.exc = 1'b1;
        end else begin
          d.st = DBC_MW;
        end
      end
      DBC_MX: begin
        if (q.wcnt == `DBC_EXC_WAITS) begin
          d.st = DBC_M4;
        end else begin
          d.wcnt = q.wcnt + 2'h1;
        end
      end
      DBC_MW: begin
        if (tack || exc) begin
          d.st = DBC_M4;
          d.exc = exc && !tack;
        end
      end
      DBC_M4: d.st = DBC_M5;
      DBC_M5: d.st = DBC_M6;
      DBC_M6: begin
        d.st = DBC_M7;
        d.rdat = {q.lanes[1] ? ad_i[15:8] : 8'h00,
                  q.lanes[0] ? ad_i[7:0] : 8'h00};
        d.as_n = 1'b1;
        d.ub_n = 1'b1;
        d.lb_n = 1'b1;
        d.en_n = 1'b1;
      end
      DBC_M7: begin
        d.st = DBC_IDLE;
        d.en_oe = 1'b0;
        d.dir_oe = 1'b0;
        d.mst_oe = 1'b0;
        d.ack_n = 1'b1;
        d.end_n = 1'b1;
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      default: d.st = DBC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  dbc_fifo #(.W(`DBC_FIFO_W), .D(`DBC_FIFO_D)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(q.push),
    .in_data_i(q.pdat),
    .in_ready_o(fifo_rdy),
    .out_valid_o(wr_valid_o),
    .out_data_o(wr_data_o),
    .out_ready_i(wr_ready_i)
  );

  assign ad_o = q.ad;
  assign ad_oe_o = q.ad_oe;
  assign buffer_direction_o = q.dir;
  assign buffer_direction_oe_o = q.dir_oe;
  assign buffer_enable_n_o = q.en_n;
  assign buffer_enable_oe_o = q.en_oe;
  assign transfer_acknowledge_n_o = q.tack_n;
  assign transfer_acknowledge_oe_o = q.tack_oe;
  assign function_code_o = q.fc;
  assign addr_lo_o = q.alo;
  assign master_oe_o = q.mst_oe;
  assign upper_address_strobe_n_o = q.uas_n;
  assign address_strobe_n_o = q.as_n;
  assign rw_o = q.rw;
  assign upper_byte_strobe_n_o = q.ub_n;
  assign lower_byte_strobe_n_o = q.lb_n;
  assign periph_ack_n_o = q.ack_n;
  assign block_end_n_o = q.end_n;
  assign dma_busy_o = q.busy;
  assign dma_done_o = q.done;
  assign dma_exc_o = q.exc;
  assign dma_data_o = q.rdat;
  assign cs_error_o = q.cs_err;
  assign addr_error_o = q.aerr;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr;
    q.st == DBC_M0 && !upper_address_strobe_n_o && rw_o && ad_oe_o;
  endsequence
  sequence s_strobe;
    q.st == DBC_M2 && upper_address_strobe_n_o && !address_strobe_n_o && !buffer_direction_o;
  endsequence

  rd_answer_a: assert property (q.st == DBC_RD |-> !transfer_acknowledge_n_o &&
    buffer_direction_o && ad_oe_o && !buffer_enable_n_o) else $error("read answer wrong");
  rd_release_a: assert property (q.st == DBC_RD && !cs |=> !ad_oe_o &&
    !transfer_acknowledge_oe_o && !buffer_enable_oe_o) else $error("read not released");
  wr_order_a: assert property (q.st == DBC_WRE |-> transfer_acknowledge_n_o &&
    !buffer_direction_o && !buffer_enable_n_o) else $error("write ack too early");
  iak_vector_a: assert property (q.st == DBC_IAK && $stable(vec) |->
    ad_o[7:0] == $past(vec) || $changed(q.st)) else $error("vector wrong");
  s0_to_s2_a: assert property (s_addr |-> ##2 s_strobe)
    else $error("address phase wrong");
  no_wait_a: assert property (q.st == DBC_M3 && tack |=> q.st == DBC_M4)
    else $error("wait inserted");
  two_waits_a: assert property (q.st == DBC_M3 && !tack && exc |=>
    q.st == DBC_MX [*2] ##1 q.st == DBC_M4) else $error("exception waits wrong");
  cs_err_a: assert property (q.busy && cs && !q.seen[0] |=> cs_error_o &&
    q.st != DBC_RD && q.st != DBC_WRE) else $error("select while master missed");
  iak_err_a: assert property (q.busy && iak && !q.seen[1] |=> addr_error_o[$past(q.ch)])
    else $error("address error missed");
endmodule // dbc_bus

// file: include/dbc_cfg.svh
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH

// ************************************************************
// Bus exception codes
// ************************************************************
`define DBC_BEC_NORMAL 3'h7
`define DBC_BEC_BERR 3'h6
`define DBC_BEC_RETRY 3'h5
`define DBC_BEC_RELQ 3'h4

// ************************************************************
// Synchroniser vector layout
// ************************************************************
`define DBC_SY_CS 0
`define DBC_SY_IAK 1
`define DBC_SY_RW 2
`define DBC_SY_UB 3
`define DBC_SY_LB 4
`define DBC_SY_TACK 5
`define DBC_SY_BEC 8:6
`define DBC_SY_ADR 15:9
`define DBC_SY_DAT 31:16

// ************************************************************
// Timing, reset and record buffer size values
// ************************************************************
`define DBC_EXC_WAITS 2'h2
`define DBC_REG_RST 16'h0000
`define DBC_FIFO_W 25
`define DBC_FIFO_D 8

`endif

// file: include/dbc_pkg.sv
package dbc_pkg;

  typedef enum logic [3:0] {
    DBC_IDLE = 4'b0000,
    DBC_RD = 4'b0001,
    DBC_WRE = 4'b0010,
    DBC_WRA = 4'b0011,
    DBC_IAK = 4'b0100,
    DBC_M0 = 4'b0101,
    DBC_M1 = 4'b0110,
    DBC_M2 = 4'b0111,
    DBC_M3 = 4'b1000,
    DBC_M4 = 4'b1001,
    DBC_M5 = 4'b1010,
    DBC_M6 = 4'b1011,
    DBC_M7 = 4'b1100,
    DBC_MW = 4'b1101,
    DBC_MX = 4'b1110
  } dbc_state_t;

endpackage

// file: tb/dbc_mem_model.sv
`include "dbc_cfg.svh"

// ********************************
// Memory or device answering the bus cycles that the block starts
// ********************************
module dbc_mem_model (
  // Clock
  input wire logic ref_clk_i,
  // Strobes from the bus master
  input wire logic upper_address_strobe_n_i,
  input wire logic address_strobe_n_i,
  // Behaviour chosen by the bench
  input wire logic [3:0] delay_i,
  input wire logic [2:0] exc_i,
  input wire logic [15:0] data_i,
  // Answer
  output logic transfer_acknowledge_n_o,
  output logic [2:0] bus_exception_code_o,
  output logic [15:0] ad_o,
  output logic drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  initial begin
    wait_q = 4'h0;
    transfer_acknowledge_n_o = 1'b1;
    bus_exception_code_o = `DBC_BEC_NORMAL;
    ad_o = 16'h0000;
    drive_o = 1'b0;
  end

  // The released bus toggles every cycle, so stale data cannot pass for a good read.
  // Access time counts from the upper address strobe, so a fast device can end S3 unwaited.
  always @(negedge ref_clk_i) begin
    if (address_strobe_n_i && upper_address_strobe_n_i) begin
      wait_q <= 4'h0;
      transfer_acknowledge_n_o <= 1'b1;
      bus_exception_code_o <= `DBC_BEC_NORMAL;
      drive_o <= 1'b0;
      ad_o <= ~ad_o;
    end else begin
      if (wait_q != 4'hF) begin
        wait_q <= wait_q + 4'h1;
      end
      drive_o <= !address_strobe_n_i;
      ad_o <= address_strobe_n_i ? ~ad_o : data_i;
      if (wait_q >= delay_i) begin
        if (exc_i == `DBC_BEC_NORMAL) begin
          transfer_acknowledge_n_o <= 1'b0;
        end else begin
          bus_exception_code_o <= exc_i;
        end
      end
    end
  end
endmodule // dbc_mem_model

// file: tb/test_dbc_bus.sv
`include "dbc_cfg.svh"

module test_dbc_bus;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_i, cs_n, iak_n, rw, ub_n, lb_n, start, to_dev, last, wr_rdy;
  logic [6:0] adr, adr_o;
  logic [15:0] tb_ad, ad_i, ad_o, dma_data, mem_ad, mem_data;
  logic [3:0] pend, err, aerr, mem_dly;
  logic [1:0] lanes;
  logic [2:0] fc_o, bec, mem_exc;
  logic [23:0] baddr;
  logic [24:0] wr_data;
  logic ad_oe, dir, dir_oe, en_n, en_oe, tk_n, tk_oe, moe, uas_n, as_n, rw_o, ubo_n, lbo_n;
  logic pack_n, bend_n, done, exc, cs_err, wr_val, mem_tk_n, mem_drv, busy;
  int fails = 0;
  int num_checks = 0;
  logic [24:0] rec_q[$];

  assign ad_i = mem_drv ? mem_ad : tb_ad;
  always #5 ref_clk_i = ~ref_clk_i;

  dbc_bus dbc_bus_i (
    .ref_clk_i, .rst_i, .chip_select_n_i(cs_n), .interrupt_acknowledge_n_i(iak_n),
    .rw_i(rw), .upper_byte_strobe_n_i(ub_n), .lower_byte_strobe_n_i(lb_n), .addr_lo_i(adr),
    .ad_i, .ad_o, .ad_oe_o(ad_oe), .buffer_direction_o(dir), .buffer_direction_oe_o(dir_oe),
    .buffer_enable_n_o(en_n), .buffer_enable_oe_o(en_oe), .transfer_acknowledge_n_i(mem_tk_n),
    .transfer_acknowledge_n_o(tk_n), .transfer_acknowledge_oe_o(tk_oe),
    .bus_exception_code_i(bec), .function_code_o(fc_o), .addr_lo_o(adr_o), .master_oe_o(moe),
    .upper_address_strobe_n_o(uas_n), .address_strobe_n_o(as_n), .rw_o,
    .upper_byte_strobe_n_o(ubo_n), .lower_byte_strobe_n_o(lbo_n), .periph_ack_n_o(pack_n),
    .block_end_n_o(bend_n), .irq_pending_i(pend), .irq_error_i(err),
    .normal_vector_reg_i(32'h4433_2211), .error_vector_reg_i(32'h8877_6655),
    .dma_start_i(start), .dma_chan_i(2'h1), .dma_fc_i(3'h5), .dma_addr_i(baddr[23:1]),
    .dma_lanes_i(lanes), .dma_to_dev_i(to_dev), .dma_last_i(last), .dma_busy_o(busy),
    .dma_done_o(done), .dma_exc_o(exc), .dma_data_o(dma_data), .cs_error_o(cs_err),
    .addr_error_o(aerr), .wr_valid_o(wr_val), .wr_data_o(wr_data), .wr_ready_i(wr_rdy)
  );

  dbc_mem_model dbc_mem_model_i (
    .ref_clk_i, .upper_address_strobe_n_i(uas_n), .address_strobe_n_i(as_n),
    .delay_i(mem_dly), .exc_i(mem_exc),
    .data_i(mem_data), .transfer_acknowledge_n_o(mem_tk_n), .bus_exception_code_o(bec),
    .ad_o(mem_ad), .drive_o(mem_drv)
  );

  // ********************************
  // Reporting
  // ********************************
  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task expire();
    chk(32'h0000_0000, 32'h0000_0001);
    finish_test();
  endtask

  // ********************************
  // Processor side cycles
  // ********************************
  task bus_start(input logic r, input logic [6:0] a, input logic u, input logic l,
                 input logic [15:0] d);
    @(negedge ref_clk_i);
    rw = r;
    adr = a;
    ub_n = u;
    lb_n = l;
    tb_ad = d;
    cs_n = 1'b0;
  endtask

  // Waits for the acknowledge, checks the held answer, then ends the cycle.
  task bus_end(input logic r, input logic [15:0] exp, input logic ik);
    int n;
    for (n = 0; n < 40 && tk_n !== 1'b0; n++) @(negedge ref_clk_i);
    if (n == 40) expire();
    repeat (3) @(negedge ref_clk_i);
    chk({tk_n, dir, en_n, ad_oe}, {1'b0, r, 1'b0, r});
    if (r) chk(ad_o, exp);
    if (ik) iak_n = 1'b1;
    else cs_n = 1'b1;
    for (n = 0; n < 40 && tk_oe !== 1'b0; n++) @(negedge ref_clk_i);
    if (n == 40) expire();
    chk({ad_oe, dir_oe, en_oe}, 3'h0);
  endtask

  task drain();
    int n;
    for (n = 0; n < 40 && wr_val !== 1'b1; n++) @(negedge ref_clk_i);
    if (n == 40) expire();
    chk(wr_data, rec_q.pop_front());
    wr_rdy = 1'b1;
    @(negedge ref_clk_i);
    wr_rdy = 1'b0;
  endtask

  task test_regs();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = 16'hA500 + 16'(i);
      bus_start(1'b0, 7'h08 + 7'(i), 1'b0, 1'b0, d);
      bus_end(1'b0, 16'h0000, 1'b0);
      rec_q.push_back({7'h08 + 7'(i), 2'b00, d});
    end
    // The buffer is full now, so the upper byte write must wait for a free slot.
    bus_start(1'b0, 7'h0B, 1'b0, 1'b1, 16'h7E99);
    repeat (10) @(negedge ref_clk_i);
    chk(tk_n, 1'b1);
    drain();
    bus_end(1'b0, 16'h0000, 1'b0);
    rec_q.push_back({7'h0B, 2'b01, 16'h7E99});
    repeat (8) drain();
    chk(wr_val, 1'b0);
    bus_start(1'b1, 7'h0B, 1'b0, 1'b0, 16'h0000);
    bus_end(1'b1, 16'h7E03, 1'b0);
    bus_start(1'b1, 7'h0F, 1'b1, 1'b0, 16'h0000);
    bus_end(1'b1, 16'hA507, 1'b0);
  endtask

  task interrupt_acknowledge(input logic [3:0] p, input logic [3:0] e, input logic [15:0] exp);
    @(negedge ref_clk_i);
    pend = p;
    err = e;
    adr = 7'h7F;
    ub_n = 1'b1;
    lb_n = 1'b1;
    iak_n = 1'b0;
    bus_end(1'b1, exp, 1'b1);
  endtask

  // ********************************
  // Master cycles
  // ********************************
  task dma_go(input logic td, input logic ls, input logic [1:0] ln, input logic [2:0] ex,
              input logic [3:0] dl);
    int n;
    @(negedge ref_clk_i);
    to_dev = td;
    last = ls;
    lanes = ln;
    mem_exc = ex;
    mem_dly = dl;
    start = 1'b1;
    for (n = 0; n < 40 && uas_n !== 1'b0; n++) @(negedge ref_clk_i);
    if (n == 40) expire();
    start = 1'b0;
    chk({moe, rw_o, busy, fc_o, adr_o, ad_o}, {3'b111, 3'h5, baddr[7:1], baddr[23:8]});
    chk({pack_n, bend_n}, 2'b11);
    for (n = 0; n < 40 && as_n !== 1'b0; n++) @(negedge ref_clk_i);
    if (n == 40) expire();
    chk({uas_n, ubo_n, lbo_n, dir}, {1'b1, ~ln, 1'b0});
    chk({pack_n, bend_n}, {~td, ~(td & ls)});
    @(negedge ref_clk_i);
    chk({ad_oe, en_n}, 2'b00);
  endtask

  task dma_fin(input logic ex, input logic [15:0] d, output int lat);
    for (lat = 0; lat < 60 && done !== 1'b1; lat++) @(negedge ref_clk_i);
    if (lat == 60) expire();
    chk(exc, ex);
    if (!ex) chk(dma_data, d);
    @(negedge ref_clk_i);
    chk({moe, ad_oe, busy}, 3'b000);
  endtask

  task test_master();
    int a, b, c;
    mem_data = 16'h5AC3;
    dma_go(1'b0, 1'b0, 2'b01, `DBC_BEC_NORMAL, 4'h0);
    dma_fin(1'b0, 16'h00C3, a);
    dma_go(1'b1, 1'b1, 2'b11, `DBC_BEC_RETRY, 4'h0);
    dma_fin(1'b1, 16'h0000, b);
    chk(b, a + 2);
    dma_go(1'b0, 1'b0, 2'b10, `DBC_BEC_NORMAL, 4'h4);
    dma_fin(1'b0, 16'h5A00, c);
    chk(c, a + 3);
  endtask

  task test_master_cs();
    int n;
    dma_go(1'b1, 1'b0, 2'b11, `DBC_BEC_NORMAL, 4'hF);
    bus_start(1'b1, 7'h08, 1'b0, 1'b0, 16'h0000);
    for (n = 0; n < 20 && cs_err !== 1'b1; n++) @(negedge ref_clk_i);
    if (n == 20) expire();
    chk(tk_oe, 1'b0);
    cs_n = 1'b1;
    @(negedge ref_clk_i);
    iak_n = 1'b0;
    for (n = 0; n < 20 && aerr !== 4'b0010; n++) @(negedge ref_clk_i);
    if (n == 20) expire();
    chk({aerr, tk_oe}, 5'b0010_0);
    iak_n = 1'b1;
    dma_fin(1'b0, 16'h5AC3, n);
  endtask

  initial begin
    rst_i = 1'b1;
    cs_n = 1'b1;
    iak_n = 1'b1;
    rw = 1'b1;
    ub_n = 1'b1;
    lb_n = 1'b1;
    adr = 7'h00;
    tb_ad = 16'h0000;
    start = 1'b0;
    to_dev = 1'b0;
    last = 1'b0;
    wr_rdy = 1'b0;
    pend = 4'h0;
    err = 4'h0;
    baddr = 24'hAB_CDE4;
    lanes = 2'b11;
    mem_exc = `DBC_BEC_NORMAL;
    mem_dly = 4'h0;
    mem_data = 16'h0000;
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    chk({ad_oe, moe, tk_oe, rw_o, tk_n}, 5'b00011);
    test_regs();
    interrupt_acknowledge(4'b0110, 4'b0000, 16'h0022);
    interrupt_acknowledge(4'b1100, 4'b0100, 16'h0077);
    test_master();
    test_master_cs();
    finish_test();
  end
endmodule // test_dbc_bus
